// ===== rtl/ivp_map.vh
// Vector numbers, level field layout and tables for the vector priority resolver
`ifndef IVP_MAP_VH
`define IVP_MAP_VH

// ---------------------------------------------------------------
// Source slots (bit positions of the request vector)
// ---------------------------------------------------------------
`define IVP_NSRC 29
`define IVP_SLOT_NMI 0
`define IVP_SLOT_SLEEP 1
`define IVP_SLOT_EXT0 2
`define IVP_SLOT_WDOG 14
`define IVP_SLOT_CONV 15
`define IVP_SLOT_TMR0 16
`define IVP_SLOT_TMR1 21
`define IVP_SLOT_TMR2 25

// ---------------------------------------------------------------
// Vector numbers
// ---------------------------------------------------------------
`define IVP_VEC_NMI 8'h07
`define IVP_VEC_SLEEP 8'h12
`define IVP_VEC_EXT0 8'h40
`define IVP_VEC_WDOG 8'h51
`define IVP_VEC_CONV 8'h56
`define IVP_VEC_TMR0 8'h58
`define IVP_VEC_NONE 8'h00

// ---------------------------------------------------------------
// Level fields: four 3-bit fields per 16-bit level register
// ---------------------------------------------------------------
`define IVP_LVL_W 3
`define IVP_FIELD_LSB_0 12
`define IVP_FIELD_LSB_1 8
`define IVP_FIELD_LSB_2 4
`define IVP_FIELD_LSB_3 0
`define IVP_OFFSET_SHIFT 2
`define IVP_MODE_PRIO 2'h2

// Per-slot activation permissions (bit n = slot n)
`define IVP_XFER_OK 29'h066FBFFC
`define IVP_DMA_OK 29'h02218000

`endif

// ===== rtl/ivp_resolver.v
// Interrupt vector priority resolver: picks the winning request and its vector
`timescale 1ns/10ps
`include "ivp_map.vh"

module ivp_resolver #(
   parameter NSRC = `IVP_NSRC
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Control
   input wire [1:0] ctrl_mode,
   // Level registers A, B, C, E, F, G
   input wire [15:0] level_reg_a,
   input wire [15:0] level_reg_b,
   input wire [15:0] level_reg_c,
   input wire [15:0] level_reg_e,
   input wire [15:0] level_reg_f,
   input wire [15:0] level_reg_g,
   // Request lines, one per slot, from the same clock domain
   input wire [NSRC-1:0] req_in,
   // Result to the core
   output reg irq_valid_reg,
   output reg [7:0] vector_num_reg,
   output reg [9:0] vector_offset_reg,
   output reg [2:0] vector_level_reg,
   output reg nonmaskable_reg,
   output reg xfer_start_ok_reg,
   output reg dma_start_ok_reg
);

   // ---------------------------------------------------------------
   // Per-slot vector number and level lookup
   // ---------------------------------------------------------------
   wire [7:0] slot_vec [0:NSRC-1];
   wire [2:0] slot_lvl [0:NSRC-1];
   wire [NSRC-1:0] xfer_ok = `IVP_XFER_OK;
   wire [NSRC-1:0] dma_ok = `IVP_DMA_OK;

   // Six level registers flattened: field k sits in register k/4
   wire [95:0] lvl_regs = {level_reg_g, level_reg_f, level_reg_e,
                           level_reg_c, level_reg_b, level_reg_a};

   function [4:0] field_idx;
      input integer s;
      integer t;
      begin
         t = s - `IVP_SLOT_EXT0;
         if (s >= `IVP_SLOT_EXT0 && s < `IVP_SLOT_WDOG)
            field_idx = t[4:0];
         else if (s == `IVP_SLOT_WDOG)
            field_idx = 5'h0D; // Reg E, bits 10:8
         else if (s == `IVP_SLOT_CONV)
            field_idx = 5'h11; // Reg F, bits 10:8
         else if (s < `IVP_SLOT_TMR1)
            field_idx = 5'h12;
         else if (s < `IVP_SLOT_TMR2)
            field_idx = 5'h13;
         else
            field_idx = 5'h14;
      end
   endfunction

   function [7:0] vec_of;
      input integer s;
      integer t;
      integer u;
      begin
         t = s - `IVP_SLOT_EXT0;
         u = s - `IVP_SLOT_TMR0;
         if (s == `IVP_SLOT_NMI)
            vec_of = `IVP_VEC_NMI;
         else if (s == `IVP_SLOT_SLEEP)
            vec_of = `IVP_VEC_SLEEP;
         else if (s < `IVP_SLOT_WDOG)
            vec_of = `IVP_VEC_EXT0 + t[7:0];
         else if (s == `IVP_SLOT_WDOG)
            vec_of = `IVP_VEC_WDOG;
         else if (s == `IVP_SLOT_CONV)
            vec_of = `IVP_VEC_CONV;
         else
            vec_of = `IVP_VEC_TMR0 + u[7:0];
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < NSRC; g = g + 1) begin : g_slot
         localparam [4:0] FI = field_idx(g);
         localparam integer RB = (FI / 4) * 16;
         localparam integer FB = (FI % 4 == 0) ? `IVP_FIELD_LSB_0 :
                                 (FI % 4 == 1) ? `IVP_FIELD_LSB_1 :
                                 (FI % 4 == 2) ? `IVP_FIELD_LSB_2 : `IVP_FIELD_LSB_3;
         assign slot_vec[g] = vec_of(g);
         // Unranked sources get the top level so they always beat maskable ones
         if (g == `IVP_SLOT_NMI || g == `IVP_SLOT_SLEEP) begin : g_fixed
            assign slot_lvl[g] = 3'h7;
         end else begin : g_prog
            assign slot_lvl[g] = lvl_regs[RB+FB+2:RB+FB];
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Arbitration
   // ---------------------------------------------------------------
   // Both winners are worked out every cycle and the mode only picks
   // one of them, so a mode change takes effect on the next edge.
   reg def_found;
   reg [4:0] def_win;
   reg lvl_found;
   reg [4:0] lvl_win;
   reg [2:0] best_lvl;
   reg nm_pend;
   reg found;
   reg [4:0] win;
   integer i;
   integer j;
   wire prio_mode = (ctrl_mode == `IVP_MODE_PRIO);

   // Default order: slots are in vector order, so the last hit of a
   // downward scan is the lowest vector
   always @* begin
      def_found = 1'h0;
      def_win = 5'h00;
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
         if (req_in[i]) begin
            def_found = 1'h1;
            def_win = i[4:0];
         end
      end
   end

   // Level order: a greater-or-equal compare on the downward scan
   // leaves the lowest vector among equal levels
   always @* begin
      lvl_found = 1'h0;
      lvl_win = 5'h00;
      best_lvl = 3'h0;
      for (j = NSRC - 1; j >= 0; j = j - 1) begin
         if (req_in[j] && (!lvl_found || slot_lvl[j] >= best_lvl)) begin
            lvl_found = 1'h1;
            lvl_win = j[4:0];
            best_lvl = slot_lvl[j];
         end
      end
   end

   // Nonmaskable requests win in every mode, pin request before sleep
   always @* begin
      nm_pend = req_in[`IVP_SLOT_NMI] | req_in[`IVP_SLOT_SLEEP];
      found = prio_mode ? lvl_found : def_found;
      win = prio_mode ? lvl_win : def_win;
      if (nm_pend) begin
         win = req_in[`IVP_SLOT_NMI] ? 5'h00 : 5'h01;
      end
   end

   // ---------------------------------------------------------------
   // Next result
   // ---------------------------------------------------------------
   // An idle cycle shows all zeros, so the core never sees a stale vector
   reg irq_valid_next;
   reg [7:0] vector_num_next;
   reg [9:0] vector_offset_next;
   reg [2:0] vector_level_next;
   reg nonmaskable_next;
   reg xfer_start_ok_next;
   reg dma_start_ok_next;

   always @* begin
      irq_valid_next = 1'h0;
      vector_num_next = `IVP_VEC_NONE;
      vector_offset_next = 10'h000;
      vector_level_next = 3'h0;
      nonmaskable_next = nm_pend;
      xfer_start_ok_next = 1'h0;
      dma_start_ok_next = 1'h0;
      if (found) begin
         irq_valid_next = 1'h1;
         vector_num_next = slot_vec[win];
         vector_offset_next = {slot_vec[win], 2'h0};
         vector_level_next = slot_lvl[win];
         xfer_start_ok_next = xfer_ok[win];
         dma_start_ok_next = dma_ok[win];
      end
   end

   // ---------------------------------------------------------------
   // Registered result
   // ---------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_valid_reg <= 1'h0;
         vector_num_reg <= `IVP_VEC_NONE;
         vector_offset_reg <= 10'h000;
         vector_level_reg <= 3'h0;
         nonmaskable_reg <= 1'h0;
         xfer_start_ok_reg <= 1'h0;
         dma_start_ok_reg <= 1'h0;
      end else begin
         irq_valid_reg <= irq_valid_next;
         vector_num_reg <= vector_num_next;
         vector_offset_reg <= vector_offset_next;
         vector_level_reg <= vector_level_next;
         nonmaskable_reg <= nonmaskable_next;
         xfer_start_ok_reg <= xfer_start_ok_next;
         dma_start_ok_reg <= dma_start_ok_next;
      end
   end

endmodule

// ===== test/ivp_resolver_monitor.sv
// Checker for the vector priority resolver outputs
`timescale 1ns/10ps
// ----
// Checker
// ----
module ivp_resolver_monitor (
   // Inputs seen at the ports
   input logic clk_sys,
   input logic rst_n,
   input logic [1:0] ctrl_mode,
   input logic [28:0] req_in,
   // Results
   input logic irq_valid_reg,
   input logic [7:0] vector_num_reg,
   input logic [9:0] vector_offset_reg,
   input logic nonmaskable_reg,
   input logic xfer_start_ok_reg,
   input logic dma_start_ok_reg
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   nmi_vector_a: assert property (req_in[0] |=> vector_num_reg == 8'h07 && nonmaskable_reg)
      else $error("nmi vector wrong");
   sleep_vector_a: assert property (req_in[1:0] == 2'h2 |=> vector_num_reg == 8'h12)
      else $error("sleep vector wrong");
   offset_scale_a: assert property (irq_valid_reg |-> vector_offset_reg == {vector_num_reg, 2'h0})
      else $error("offset wrong");
   idle_zero_a: assert property (req_in == 29'h0 |=> !irq_valid_reg && vector_num_reg == 8'h00)
      else $error("idle not zero");
   default_order_a: assert property (ctrl_mode != 2'h2 && req_in[2:0] == 3'h4 |=> vector_num_reg == 8'h40)
      else $error("default order wrong");
   fixed_no_start_a: assert property (nonmaskable_reg |-> !xfer_start_ok_reg && !dma_start_ok_reg)
      else $error("fixed source starts transfer");
   reserved_vec_a: assert property (irq_valid_reg |-> !(vector_num_reg inside {[8'h4C:8'h50], [8'h52:8'h55], 8'h57}))
      else $error("reserved vector raised");
   dma_subset_a: assert property (dma_start_ok_reg |-> xfer_start_ok_reg && vector_num_reg inside {8'h56, 8'h58, 8'h5D, 8'h61})
      else $error("dma start wrong");
   cover property (req_in[0]);
   cover property (dma_start_ok_reg);
   cover property (ctrl_mode == 2'h2 && irq_valid_reg);
endmodule
bind ivp_resolver ivp_resolver_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl_mode(ctrl_mode),
   .req_in(req_in), .irq_valid_reg(irq_valid_reg), .vector_num_reg(vector_num_reg),
   .vector_offset_reg(vector_offset_reg), .nonmaskable_reg(nonmaskable_reg),
   .xfer_start_ok_reg(xfer_start_ok_reg), .dma_start_ok_reg(dma_start_ok_reg));

// ===== test/ivp_core_model.sv
// Core side model: takes the vector that the core would fetch
`timescale 1ns/10ps
module ivp_core_model (
   input logic clk_sys,
   input logic irq_valid_reg,
   input logic [9:0] vector_offset_reg,
   output logic [7:0] taken_vec
);
   // Core derives the vector from the table offset, so offset faults show
   always @(posedge clk_sys) taken_vec <= irq_valid_reg ? vector_offset_reg[9:2] : 8'h00;
endmodule

// ===== test/ivp_resolver_bench.sv
// Testbench for the vector priority resolver
`timescale 1ns/10ps
module ivp_resolver_bench;
   logic clk_sys = 0, rst_n = 0;
   logic [1:0] md = 0;
   logic [28:0] rq = 0;
   logic [15:0] la = 0, lf = 0;
   logic [7:0] ev;
   logic [2:0] el;
   logic [1:0] ef;
   wire v, nm, xo, dk;
   wire [7:0] vn, tv;
   wire [9:0] vo;
   wire [2:0] vl;
   int fail_count = 0, checks_done = 0;
   // Row: mode, requests, levels a/b/c, levels e/f/g, vector, level, xfer/dma
   logic [75:0] rows [10] = '{
      {2'h0, 29'h4, 16'h0, 16'h0, 8'h40, 3'h0, 2'h2}, {2'h0, 29'h12000, 16'h0, 16'h0, 8'h4B, 3'h0, 2'h2},
      {2'h0, 29'h7, 16'h0, 16'h0, 8'h07, 3'h7, 2'h0}, {2'h0, 29'h6, 16'h0, 16'h0, 8'h12, 3'h7, 2'h0},
      {2'h2, 29'h10004, 16'h1000, 16'h40, 8'h58, 3'h4, 2'h3}, {2'h2, 29'h88, 16'h100, 16'h0, 8'h41, 3'h1, 2'h2},
      {2'h2, 29'hC004, 16'h0, 16'h700, 8'h51, 3'h7, 2'h0}, {2'h0, 29'h2100000, 16'h0, 16'h0, 8'h5C, 3'h0, 2'h0},
      {2'h0, 29'h2000000, 16'h0, 16'h0, 8'h61, 3'h0, 2'h3}, {2'h2, 29'h8000, 16'h0, 16'h0, 8'h56, 3'h0, 2'h3}};
   ivp_resolver dut (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl_mode(md), .level_reg_a(la),
      .level_reg_b(la), .level_reg_c(la), .level_reg_e(lf), .level_reg_f(lf), .level_reg_g(lf),
      .req_in(rq), .irq_valid_reg(v), .vector_num_reg(vn), .vector_offset_reg(vo),
      .vector_level_reg(vl), .nonmaskable_reg(nm), .xfer_start_ok_reg(xo), .dma_start_ok_reg(dk));
   ivp_core_model core (.clk_sys(clk_sys), .irq_valid_reg(v), .vector_offset_reg(vo), .taken_vec(tv));
   task chk(input logic [9:0] g, input logic [9:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task results;
      if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task step;
      @(posedge clk_sys);
      #1;
   endtask
   initial forever #4 clk_sys = ~clk_sys;
   initial begin
      repeat (3) @(posedge clk_sys);
      #1 rst_n = 1;
      for (int i = 0; i < 10; i++) begin
         {md, rq, la, lf, ev, el, ef} = rows[i];
         step;
         chk(vn, ev);
         chk(vl, el);
         chk({xo, dk}, ef);
         chk(nm, |rq[1:0]);
         step;
         chk(tv, ev);
      end
      // Same levels outside mode 2 fall back to vector order
      md = 2'h1; la = 16'h1000; lf = 16'h40; rq = 29'h10004;
      step;
      chk(vn, 8'h40);
      rq = 29'h0;
      step;
      chk({v, vn}, 9'h0);
      // Reset in mid-run clears the result at once
      rq = 29'h4;
      step;
      rst_n = 0;
      #1 chk(v, 1'h0);
      step;
      rst_n = 1;
      step;
      chk(vo, 10'h100);
      results;
   end
endmodule
